// file: efp_seq.sv
// Float-wait and page-mode read sequencer for external static memory.
// Assumes one access request at a time from the on-chip bus, held
// until acknowledged, and per-chip-select settings as plain ports.
`timescale 1ns/100ps
module efp_seq (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Access request from the on-chip bus
  input wire logic req_valid,
  input wire logic req_internal,
  input wire logic req_write,
  input wire logic [efp_pkg::CS_W-1:0] req_cs,
  input wire logic [efp_pkg::ADDR_W-1:0] req_addr,
  output logic req_ack,
  // Per chip select mode configuration, flattened
  input wire logic [efp_pkg::NUM_CS*efp_pkg::TDF_W-1:0] float_wait_cycles,
  input wire logic [efp_pkg::NUM_CS-1:0] read_mode_select,
  input wire logic [efp_pkg::NUM_CS-1:0] float_optimize_select,
  input wire logic [efp_pkg::NUM_CS-1:0] page_mode_enable,
  input wire logic [efp_pkg::NUM_CS*efp_pkg::PULSE_W-1:0] cs_read_pulse_len,
  input wire logic [efp_pkg::NUM_CS*efp_pkg::PULSE_W-1:0] rd_strobe_pulse_len,
  // External memory strobes
  output logic [efp_pkg::NUM_CS-1:0] chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  // Status
  output logic float_pending,
  output logic page_open
);
  import efp_pkg::*;

  typedef enum logic [1:0] {
    EFP_IDLE,
    EFP_ACCESS,
    EFP_DONE
  } efp_phase_type;

  typedef struct packed {
    efp_phase_type phase;
    logic [PULSE_W-1:0] count;
    logic [CS_W-1:0] cs;
    logic is_read;
    logic rmode;
    logic [TDF_W-1:0] tdf;
    logic rec_valid;
    logic [CS_W-1:0] rec_cs;
    logic [PAGE_W-1:0] rec_page;
    logic ack;
    logic [NUM_CS-1:0] cs_n;
    logic rd_n;
    logic wr_n;
    logic float_busy;
    logic [TDF_W-1:0] float_left;
    logic page_flag;
  } efp_state_type;

  efp_state_type cur;
  efp_state_type next_cur;

  // ****************************************************************
  // Per chip select field unpacking
  // ****************************************************************
  logic [TDF_W-1:0] tdf_of [NUM_CS];
  logic [PULSE_W-1:0] first_len_of [NUM_CS];
  logic [PULSE_W-1:0] page_len_of [NUM_CS];

  // Each chip select keeps its own settings
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CS; gi++) begin : g_cfg
      assign tdf_of[gi] = float_wait_cycles[gi*TDF_W +: TDF_W];
      assign first_len_of[gi] = cs_read_pulse_len[gi*PULSE_W +: PULSE_W];
      assign page_len_of[gi] = rd_strobe_pulse_len[gi*PULSE_W +: PULSE_W];
    end
  endgenerate

  // ****************************************************************
  // Float timer
  // ****************************************************************
  logic tmr_load;
  logic tmr_busy;
  logic [CS_W-1:0] tmr_cs;
  logic [TDF_W-1:0] tmr_cycles;
  logic [CS_W-1:0] tmr_cs_owner;

  efp_float_timer u_float (
    .mclk(mclk),
    .rst(rst),
    .load(tmr_load),
    .load_cycles(tmr_cycles),
    .load_cs(tmr_cs),
    .busy(tmr_busy),
    .owner_cs(tmr_cs_owner)
  );

  // ****************************************************************
  // Request qualification
  // ****************************************************************
  logic [PAGE_W-1:0] req_page;
  logic in_page;
  logic float_blocks;
  logic [PULSE_W-1:0] access_len;

  always_comb begin
    req_page = req_addr[ADDR_W-1:PAGE_LSB];
    // Same select and upper address bits keep the page open
    in_page = cur.rec_valid && (cur.rec_cs == req_cs)
      && (cur.rec_page == req_page) && page_mode_enable[req_cs]
      && !req_write;
    // Writes always wait; reads wait too, for the same device as for another
    // With float optimisation, the same device may be re-read at once
    // since it will drive the bus again anyway
    float_blocks = tmr_busy && !req_internal
      && (req_write || (tmr_cs_owner != req_cs)
        || !float_optimize_select[tmr_cs_owner]);
    // Short time in page, long time on a new page, no ordering check
    if (in_page) begin
      access_len = page_len_of[req_cs];
    end else begin
      access_len = first_len_of[req_cs];
    end
    if (access_len == PULSE_ZERO) begin
      access_len = PULSE_ONE;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Page mode with the wait input is left to software, no wait pin here
  always_comb begin
    next_cur = cur;
    next_cur.ack = 1'b0;
    tmr_load = 1'b0;
    tmr_cycles = cur.tdf;
    tmr_cs = cur.cs;
    unique case (cur.phase)
      EFP_IDLE: begin
        if (req_valid && req_internal) begin
          // Internal access passes now and breaks the page
          next_cur.ack = 1'b1;
          next_cur.rec_valid = 1'b0;
          next_cur.phase = EFP_DONE;
        end else if (req_valid && !float_blocks) begin
          if (!in_page) begin
            next_cur.rec_valid = 1'b0;
          end
          next_cur.phase = EFP_ACCESS;
          next_cur.count = access_len;
          next_cur.cs = req_cs;
          next_cur.is_read = !req_write;
          next_cur.rmode = read_mode_select[req_cs];
          next_cur.tdf = tdf_of[req_cs];
          next_cur.rec_cs = req_cs;
          next_cur.rec_page = req_page;
          next_cur.cs_n = CS_NONE;
          next_cur.cs_n[req_cs] = 1'b0;
          next_cur.rd_n = req_write;
          next_cur.wr_n = !req_write;
        end
      end
      EFP_ACCESS: begin
        if (cur.count == PULSE_ONE) begin
          next_cur.phase = EFP_DONE;
          next_cur.ack = 1'b1;
          next_cur.rd_n = 1'b1;
          next_cur.wr_n = 1'b1;
          // Page stays open only for page-mode reads
          next_cur.rec_valid = cur.is_read && page_mode_enable[cur.cs];
          if (next_cur.rec_valid) begin
            // Select held low while the page is open
            next_cur.cs_n = cur.cs_n;
          end else begin
            next_cur.cs_n = CS_NONE;
          end
          if (cur.is_read) begin
            // Strobe rises here, and the select too unless the page stays open; both modes
            // start counting now; the mode is stored but drives no output
            tmr_load = 1'b1;
          end
        end else begin
          next_cur.count = cur.count - PULSE_ONE;
        end
      end
      EFP_DONE: begin
        next_cur.phase = EFP_IDLE;
      end
      default: begin
        next_cur.phase = EFP_IDLE;
      end
    endcase
    // Select released whenever the page record drops, except during an access
    if (!next_cur.rec_valid && next_cur.phase != EFP_ACCESS) begin
      next_cur.cs_n = CS_NONE;
    end
    // Local copy of the timer count, so the status flag is registered
    // and matches the stall window exactly, also for a zero count
    if (tmr_load) begin
      next_cur.float_left = tmr_cycles;
    end else if (cur.float_left != TDF_ZERO) begin
      next_cur.float_left = cur.float_left - TDF_ONE;
    end
    next_cur.float_busy = (next_cur.float_left != TDF_ZERO);
    next_cur.page_flag = next_cur.rec_valid;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur <= '{phase: EFP_IDLE, count: PULSE_ZERO, cs: CS_ZERO,
        is_read: 1'b0, rmode: 1'b0, tdf: TDF_ZERO, rec_valid: 1'b0,
        rec_cs: CS_ZERO, rec_page: PAGE_ZERO, ack: 1'b0, cs_n: CS_NONE,
        rd_n: 1'b1, wr_n: 1'b1, float_busy: 1'b0, float_left: TDF_ZERO,
        page_flag: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state register
  assign req_ack = cur.ack;
  assign chip_select_n = cur.cs_n;
  assign read_strobe_n = cur.rd_n;
  assign write_strobe_n = cur.wr_n;
  assign float_pending = cur.float_busy;
  assign page_open = cur.page_flag;
endmodule

// file: efp_pkg.sv
// Shared constants and types for the external memory float-wait and
// page-mode read sequencer.
// Assumes a single master clock domain and four chip selects.
package efp_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CS = 4;
  localparam int CS_W = 2;
  localparam int ADDR_W = 24;
  localparam int TDF_W = 4;
  localparam int PULSE_W = 7;
  // Page of 8 bytes; address bits from this index up select the page
  localparam int PAGE_LSB = 3;
  localparam int PAGE_W = ADDR_W - PAGE_LSB;

  // ****************************************************************
  // Reset and constant values
  // ****************************************************************
  localparam logic [TDF_W-1:0] TDF_ZERO = 4'h0;
  localparam logic [TDF_W-1:0] TDF_ONE = 4'h1;
  localparam logic [PULSE_W-1:0] PULSE_ZERO = 7'h00;
  localparam logic [PULSE_W-1:0] PULSE_ONE = 7'h01;
  localparam logic [PAGE_W-1:0] PAGE_ZERO = 21'h00000;
  localparam logic [CS_W-1:0] CS_ZERO = 2'h0;
  localparam logic [NUM_CS-1:0] CS_NONE = 4'hF;

  typedef enum logic {
    EFP_RMODE_CS = 1'b0,
    EFP_RMODE_STROBE = 1'b1
  } efp_rmode_type;

endpackage

// file: efp_float_timer.sv
// Data-float wait counter for one pending float period.
// Assumes load pulses come from the sequencer on the same clock.
`timescale 1ns/100ps
module efp_float_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Load request with its count and owning chip select
  input wire logic load,
  input wire logic [efp_pkg::TDF_W-1:0] load_cycles,
  input wire logic [efp_pkg::CS_W-1:0] load_cs,
  // Current state of the float period
  output logic busy,
  output logic [efp_pkg::CS_W-1:0] owner_cs
);
  import efp_pkg::*;

  typedef struct packed {
    logic [TDF_W-1:0] count;
    logic [CS_W-1:0] cs;
  } eft_state_type;

  eft_state_type cur;
  eft_state_type next_cur;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // A fresh load replaces any period still running
  always_comb begin
    next_cur = cur;
    if (load) begin
      next_cur.count = load_cycles;
      next_cur.cs = load_cs;
    end else if (cur.count != TDF_ZERO) begin
      next_cur.count = cur.count - TDF_ONE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign busy = (cur.count != TDF_ZERO);
  assign owner_cs = cur.cs;
endmodule

// file: efp_seq_properties.sv
// Concurrent checks on the float-wait and page-mode read sequencer.
// Assumes it is bound to efp_seq and sees only that module's ports.
`timescale 1ns/100ps
module efp_seq_properties
  import efp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request side
  input wire logic req_valid,
  input wire logic req_internal,
  input wire logic req_write,
  input wire logic [efp_pkg::CS_W-1:0] req_cs,
  input wire logic req_ack,
  // Configuration
  input wire logic [efp_pkg::NUM_CS*efp_pkg::TDF_W-1:0] float_wait_cycles,
  input wire logic [efp_pkg::NUM_CS-1:0] float_optimize_select,
  // Strobes and status
  input wire logic [efp_pkg::NUM_CS-1:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic float_pending,
  input wire logic page_open
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [TDF_W-1:0] cur_tdf;
  logic [TDF_W-1:0] fl_set;
  logic [4:0] fl_run;
  // Count of the accessed select; request fields hold until acknowledge
  assign cur_tdf = float_wait_cycles[req_cs*TDF_W +: TDF_W];
  // Length of each float period against the count latched at read end
  always_ff @(posedge mclk) begin
    if (rst) begin
      fl_run <= 5'h00;
      fl_set <= TDF_ZERO;
    end else begin
      // A read ending inside a running period restarts the count
      if (!float_pending) fl_run <= 5'h00;
      else if (req_ack && !req_internal && !req_write) fl_run <= 5'h01;
      else fl_run <= fl_run + 5'h01;
      if (req_ack && !req_internal && !req_write) fl_set <= cur_tdf;
    end
  end
  sequence ext_read_done;
    req_ack && !req_internal && !req_write;
  endsequence
  sequence strobe_start;
    $fell(read_strobe_n) || $fell(write_strobe_n);
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  reset_idle_a: assert property ($fell(rst) |-> chip_select_n == CS_NONE
    && read_strobe_n && !req_ack && !float_pending && !page_open)
    else $error("outputs not idle after reset");
  ack_pulse_a: assert property (req_ack |=> !req_ack)
    else $error("acknowledge longer than one cycle");
  float_start_a: assert property (
    ext_read_done ##0 (cur_tdf != TDF_ZERO) |-> float_pending)
    else $error("float not started");
  float_len_a: assert property (
    $fell(float_pending) |-> fl_run == {1'b0, fl_set})
    else $error("float length wrong");
  write_hold_a: assert property (
    $fell(write_strobe_n) |-> !$past(float_pending))
    else $error("write during float");
  read_hold_a: assert property (
    strobe_start ##0 (float_optimize_select == 4'h0)
    |-> !$past(float_pending)) else $error("access in float");
  internal_fast_a: assert property (
    $rose(req_valid) && req_internal |-> ##1 req_ack)
    else $error("internal access delayed");
  page_clear_a: assert property (
    $rose(req_valid) && req_internal |-> ##[1:2] !page_open)
    else $error("page record kept");
  select_with_strobe_a: assert property (!read_strobe_n |->
    chip_select_n != CS_NONE) else $error("read strobe without select");
endmodule
bind efp_seq efp_seq_properties u_props (.*);

// file: efp_mem_model.sv
// Behavioural external static memory that measures read strobe width.
// Assumes strobes from efp_seq on the same master clock.
`timescale 1ns/100ps
module efp_mem_model
  import efp_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Strobes from the controller
  input wire logic [efp_pkg::NUM_CS-1:0] chip_select_n,
  input wire logic read_strobe_n,
  // Low time of the last read strobe and the wait line
  output logic [7:0] rd_low_len,
  output logic ext_wait_n
);
  logic [7:0] run = 8'h00;
  // Wait stays released: page mode and wait are never combined
  assign ext_wait_n = 1'b1;
  initial rd_low_len = 8'h00;
  // A strobe without any select is not a memory access
  always @(posedge mclk) begin
    if (!read_strobe_n && chip_select_n != CS_NONE) run <= run + 8'h01;
    else if (run != 8'h00) begin
      rd_low_len <= run;
      run <= 8'h00;
    end
  end
endmodule

// file: ext_mem_float_and_page_read_test.sv
// Self-checking bench for the float-wait and page-mode sequencer.
// Assumes one request at a time, driven at the falling edge.
`timescale 1ns/100ps
module ext_mem_float_and_page_read_test;
  import efp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0, req_internal = 1'b0, req_write = 1'b0;
  logic [CS_W-1:0] req_cs = CS_ZERO;
  logic [ADDR_W-1:0] req_addr = 24'h000000, pg;
  logic [3:0] tdf [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
  logic [15:0] float_wait_cycles;
  logic [3:0] read_mode_select = 4'h0;
  logic [3:0] float_optimize_select = 4'h0;
  logic [27:0] cs_read_pulse_len = {7'h04, 7'h04, 7'h09, 7'h02};
  logic [27:0] rd_strobe_pulse_len = {7'h04, 7'h04, 7'h03, 7'h06};
  logic req_ack, read_strobe_n, write_strobe_n, float_pending, page_open;
  logic [NUM_CS-1:0] chip_select_n;
  logic [7:0] rd_low_len;
  int n_fail = 0, checks_done = 0, cnt = 0, e, x;
  int exp_q[$], exact_q[$];
  always #2.5 mclk = ~mclk;
  assign float_wait_cycles = {tdf[3], tdf[2], tdf[1], tdf[0]};
  efp_seq u_dut (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req_internal(req_internal), .req_write(req_write), .req_cs(req_cs),
    .req_addr(req_addr), .req_ack(req_ack),
    .float_wait_cycles(float_wait_cycles),
    .read_mode_select(read_mode_select),
    .float_optimize_select(float_optimize_select),
    .page_mode_enable(4'h3), .cs_read_pulse_len(cs_read_pulse_len),
    .rd_strobe_pulse_len(rd_strobe_pulse_len),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .float_pending(float_pending),
    .page_open(page_open));
  efp_mem_model u_mem (.mclk(mclk), .chip_select_n(chip_select_n),
    .read_strobe_n(read_strobe_n), .rd_low_len(rd_low_len),
    .ext_wait_n());
  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", what, want, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Latency in cycles from request to acknowledge, exact or a floor
  always @(negedge mclk) begin
    if (req_valid) cnt = cnt + 1;
    if (req_ack === 1'b1) begin
      e = exp_q.pop_front();
      x = exact_q.pop_front();
      if (x) check("latency", cnt, e);
      else check("stall", cnt >= e, 1);
      cnt = 0;
    end
  end
  // One whole request; fields held until acknowledge, then an idle cycle
  task automatic acc(input logic i, w, input logic [1:0] cs,
                     input logic [23:0] a, input int lat, input int ex);
    int k;
    exp_q.push_back(lat);
    exact_q.push_back(ex);
    req_valid <= 1'b1;
    req_internal <= i;
    req_write <= w;
    req_cs <= cs;
    req_addr <= a;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (req_ack !== 1'b1 && k < 200);
    if (k < 200) begin
      req_valid <= 1'b0;
      @(negedge mclk);
    end else begin
      n_fail++;
      complete_run();
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [3:0] tv [3];
    void'($urandom(32'h7DA3));
    read_mode_select = 4'($urandom);
    tv = '{4'h0, 4'($urandom_range(14, 2)), 4'hF};
    repeat (10) @(negedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check("select idle", chip_select_n, CS_NONE);
    check("page idle", page_open, 1'b0);
    pg = 24'($urandom) & 24'hFFFFF8;
    acc(0, 0, 0, pg, 3, 1);
    check("first strobe", rd_low_len, 8'h02);
    check("page open", page_open, 1'b1);
    acc(0, 0, 0, pg | 24'($urandom_range(7, 1)), 7, 1);
    check("in page strobe", rd_low_len, 8'h06);
    acc(0, 0, 0, pg ^ 24'h000008, 3, 1);
    acc(0, 0, 1, pg, 10, 1);
    acc(0, 0, 0, pg ^ 24'h000008, 3, 1);
    acc(1, 0, 0, pg, 1, 1);
    acc(0, 0, 0, pg ^ 24'h000008, 3, 1);
    $display("page tests done");
    foreach (tv[j]) begin
      // Let the float left by the last read of the previous round end
      repeat (16) @(negedge mclk);
      tdf[2] = tv[j];
      acc(0, 0, 2, pg, 5, 1);
      acc(0, 0, 3, pg, tv[j] + 5 - (tv[j] > 0), 1);
      acc(0, 0, 2, pg, 5, 1);
      acc(0, 1, 2, pg, tv[j] + 5 - (tv[j] > 0), 0);
      acc(0, 0, 2, pg, 5, 1);
      acc(1, 0, 0, pg, 1, 1);
      $display("float test %0d done", tv[j]);
    end
    // Optimised float: same select re-reads at once, writes still wait
    repeat (16) @(negedge mclk);
    float_optimize_select = 4'h4;
    acc(0, 0, 2, pg, 5, 1);
    acc(0, 0, 2, pg, 5, 1);
    acc(0, 1, 2, pg, 19, 1);
    float_optimize_select = 4'h0;
    $display("float optimise test done");
    complete_run();
  end
endmodule
